// ---- design/comparator_control_defines.svh ----
// Register offsets, field positions and reset values of the comparator control block
`ifndef COMPARATOR_CONTROL_DEFINES_SVH
`define COMPARATOR_CONTROL_DEFINES_SVH

// Printed offsets are not all multiples of four: they are word indices
`define IDX_CONV_CTRL_B     6'h03
`define IDX_CMP_CTRL        6'h08
`define IDX_DIG_IN_DIS      6'h14
`define IDX_CONV_CTRL_A     6'h20
`define IDX_CONV_CHANNEL    6'h21
`define IDX_IRQ_STATUS      6'h22
`define IDX_IRQ_MASK        6'h23
`define IDX_PIN_READ        6'h24

// Comparator control fields
`define CMP_POWER_OFF_BIT   7
`define CMP_BANDGAP_BIT     6
`define CMP_RESULT_BIT      5
`define CMP_FLAG_BIT        4
`define CMP_IRQ_EN_BIT      3
`define CMP_RESERVED_BIT    2
`define CMP_MODE_HI_BIT     1
`define CMP_MODE_LO_BIT     0
`define CMP_WR_MASK         8'hcb

// Converter control B fields
`define CCB_MUX_EN_BIT      6
`define CCB_WR_MASK         8'he7

// Converter control A enable and channel select low bits
`define CCA_ENABLE_BIT      7
`define CHAN_LOW_MSB        1

// Digital input disable fields
`define DID_WR_MASK         8'h3f
`define DID_POS_BIT         0
`define DID_NEG_BIT         1

`define RESET_BYTE          8'h00

`endif

// ---- design/comparator_control_logic.sv ----
// APB-attached control, status and event logic around an analog comparator
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "comparator_control_defines.svh"

module comparator_control_logic (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    input  wire logic [3:0]                        pstrb,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              comparator_raw,
    input  wire logic                              positive_pin_digital,
    input  wire logic                              negative_pin_digital,
    input  wire logic                              global_irq_enable,
    input  wire logic                              vector_taken,
    output logic                                   comparator_power_off,
    output logic                                   bandgap_select,
    output comparator_control_pkg::neg_source_t    negative_source,
    output logic                                   positive_pin_buffer_off,
    output logic                                   negative_pin_buffer_off,
    output logic                                   comparator_irq,
    output logic                                   irq
);
    import comparator_control_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  conv_ctrl_b_r,    conv_ctrl_b_nxt;
    logic [7:0]  cmp_ctrl_r,       cmp_ctrl_nxt;
    logic [7:0]  dig_in_dis_r,     dig_in_dis_nxt;
    logic [7:0]  conv_ctrl_a_r,    conv_ctrl_a_nxt;
    logic [7:0]  conv_channel_r,   conv_channel_nxt;
    logic [0:0]  irq_mask_r,       irq_mask_nxt;
    logic        sync1_r,          sync1_nxt;
    logic        sync2_r,          sync2_nxt;
    logic        prev_r,           prev_nxt;
    logic        flag_r,           flag_nxt;
    logic [31:0] prdata_r,         prdata_nxt;

    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic        event_hit;
    logic [5:0]  word_idx;
    logic        cmp_irq_req;
    logic [7:0]  cmp_ctrl_view;

    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] wmask,
                                              input logic       lane);
        merge_byte = lane ? ((old_v & ~wmask) | (new_v & wmask)) : old_v;
    endfunction : merge_byte

    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == `IDX_CONV_CTRL_B) || (idx == `IDX_CMP_CTRL) ||
                    (idx == `IDX_DIG_IN_DIS) || (idx == `IDX_CONV_CTRL_A) ||
                    (idx == `IDX_CONV_CHANNEL) || (idx == `IDX_IRQ_STATUS) ||
                    (idx == `IDX_IRQ_MASK) || (idx == `IDX_PIN_READ);
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Single-cycle access phase; slave always ready
    assign word_idx = paddr[7:2];
    assign mapped   = is_mapped(word_idx);
    assign wr_en    = psel && penable && pwrite && mapped;
    // Read data is captured in the setup cycle so it stands at the access edge
    assign rd_en    = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_r;

    // ------------------------------------------------------------------
    // Synchronizer and edge detect
    // ------------------------------------------------------------------
    always_comb begin
        sync1_nxt = comparator_raw;
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
    end

    always_comb begin
        case (event_mode_t'(cmp_ctrl_r[`CMP_MODE_HI_BIT:`CMP_MODE_LO_BIT]))
            MODE_TOGGLE:  event_hit = sync2_r != prev_r;
            MODE_FALLING: event_hit = prev_r && !sync2_r;
            MODE_RISING:  event_hit = !prev_r && sync2_r;
            default:      event_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Register next state
    // ------------------------------------------------------------------
    always_comb begin
        conv_ctrl_b_nxt  = conv_ctrl_b_r;
        cmp_ctrl_nxt     = cmp_ctrl_r;
        dig_in_dis_nxt   = dig_in_dis_r;
        conv_ctrl_a_nxt  = conv_ctrl_a_r;
        conv_channel_nxt = conv_channel_r;
        irq_mask_nxt     = irq_mask_r;
        flag_nxt         = flag_r;
        if (wr_en) begin
            case (word_idx)
                `IDX_CONV_CTRL_B:  conv_ctrl_b_nxt = merge_byte(conv_ctrl_b_r, pwdata[7:0],
                                                         `CCB_WR_MASK, pstrb[0]);
                `IDX_CMP_CTRL:     cmp_ctrl_nxt = merge_byte(cmp_ctrl_r, pwdata[7:0],
                                                         `CMP_WR_MASK, pstrb[0]);
                `IDX_DIG_IN_DIS:   dig_in_dis_nxt = merge_byte(dig_in_dis_r, pwdata[7:0],
                                                         `DID_WR_MASK, pstrb[0]);
                `IDX_CONV_CTRL_A:  conv_ctrl_a_nxt = merge_byte(conv_ctrl_a_r, pwdata[7:0],
                                                         8'hff, pstrb[0]);
                `IDX_CONV_CHANNEL: conv_channel_nxt = merge_byte(conv_channel_r, pwdata[7:0],
                                                         8'hff, pstrb[0]);
                `IDX_IRQ_MASK:     irq_mask_nxt = pstrb[0] ? pwdata[0:0] : irq_mask_r;
                default:           ;
            endcase
        end
        // Write-one-to-clear from either alias; set wins over any clear
        if (wr_en && pstrb[0] && pwdata[`CMP_FLAG_BIT] && word_idx == `IDX_CMP_CTRL)
            flag_nxt = 1'b0;
        if (wr_en && pstrb[0] && pwdata[0] && word_idx == `IDX_IRQ_STATUS)
            flag_nxt = 1'b0;
        if (vector_taken)
            flag_nxt = 1'b0;
        if (event_hit)
            flag_nxt = 1'b1;
    end

    always_comb begin
        cmp_ctrl_view = cmp_ctrl_r;
        cmp_ctrl_view[`CMP_RESULT_BIT]   = sync2_r;
        cmp_ctrl_view[`CMP_FLAG_BIT]     = flag_r;
        cmp_ctrl_view[`CMP_RESERVED_BIT] = 1'b0;
    end

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (rd_en) begin
            case (word_idx)
                `IDX_CONV_CTRL_B:  prdata_nxt = {24'h00_0000, conv_ctrl_b_r};
                `IDX_CMP_CTRL:     prdata_nxt = {24'h00_0000, cmp_ctrl_view};
                `IDX_DIG_IN_DIS:   prdata_nxt = {24'h00_0000, dig_in_dis_r};
                `IDX_CONV_CTRL_A:  prdata_nxt = {24'h00_0000, conv_ctrl_a_r};
                `IDX_CONV_CHANNEL: prdata_nxt = {24'h00_0000, conv_channel_r};
                `IDX_IRQ_STATUS:   prdata_nxt = {31'h0000_0000, flag_r};
                `IDX_IRQ_MASK:     prdata_nxt = {31'h0000_0000, irq_mask_r};
                `IDX_PIN_READ:     prdata_nxt = {30'h0000_0000,
                    negative_pin_digital && !dig_in_dis_r[`DID_NEG_BIT],
                    positive_pin_digital && !dig_in_dis_r[`DID_POS_BIT]};
                default:           prdata_nxt = 32'h0000_0000;
            endcase
        end else begin
            prdata_nxt = prdata_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_ctrl_b_r  <= `RESET_BYTE;
            cmp_ctrl_r     <= `RESET_BYTE;
            dig_in_dis_r   <= `RESET_BYTE;
            conv_ctrl_a_r  <= `RESET_BYTE;
            conv_channel_r <= `RESET_BYTE;
            irq_mask_r     <= 1'b0;
            sync1_r        <= 1'b0;
            sync2_r        <= 1'b0;
            prev_r         <= 1'b0;
            flag_r         <= 1'b0;
            prdata_r       <= 32'h0000_0000;
        end else begin
            conv_ctrl_b_r  <= conv_ctrl_b_nxt;
            cmp_ctrl_r     <= cmp_ctrl_nxt;
            dig_in_dis_r   <= dig_in_dis_nxt;
            conv_ctrl_a_r  <= conv_ctrl_a_nxt;
            conv_channel_r <= conv_channel_nxt;
            irq_mask_r     <= irq_mask_nxt;
            sync1_r        <= sync1_nxt;
            sync2_r        <= sync2_nxt;
            prev_r         <= prev_nxt;
            flag_r         <= flag_nxt;
            prdata_r       <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Analog steering and interrupt
    // ------------------------------------------------------------------
    always_comb begin
        if (conv_ctrl_b_r[`CCB_MUX_EN_BIT] && !conv_ctrl_a_r[`CCA_ENABLE_BIT])
            negative_source = neg_source_t'({1'b1, conv_channel_r[`CHAN_LOW_MSB:0]});
        else
            negative_source = NEG_PIN;
    end

    assign comparator_power_off    = cmp_ctrl_r[`CMP_POWER_OFF_BIT];
    assign bandgap_select          = cmp_ctrl_r[`CMP_BANDGAP_BIT];
    assign positive_pin_buffer_off = dig_in_dis_r[`DID_POS_BIT];
    assign negative_pin_buffer_off = dig_in_dis_r[`DID_NEG_BIT];
    // Mode or power changes can fake an edge; software masks the enable first
    assign cmp_irq_req    = flag_r && cmp_ctrl_r[`CMP_IRQ_EN_BIT];
    assign comparator_irq = cmp_irq_req && global_irq_enable;
    assign irq            = flag_r && irq_mask_r[0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sync_delay_a: assert property (sync2_r == $past(comparator_raw, 2))
        else $error("result not two cycles behind raw");
    mux_route_a: assert property (conv_ctrl_b_r[6] && !conv_ctrl_a_r[7]
        |-> negative_source[1:0] == conv_channel_r[1:0] && negative_source[2])
        else $error("negative mux channel wrong");
    pin_route_a: assert property (!conv_ctrl_b_r[6] || conv_ctrl_a_r[7]
        |-> negative_source == NEG_PIN)
        else $error("negative pin not selected");
    rise_sets_a: assert property (cmp_ctrl_r[1:0] == 2'b11 && $rose(sync2_r)
        && !$rose(prev_r) |=> flag_r)
        else $error("rising edge missed");
    reserved_quiet_a: assert property (cmp_ctrl_r[1:0] == 2'b01 && !flag_r
        && !wr_en |=> !flag_r)
        else $error("reserved mode set flag");
    irq_gate_a: assert property (comparator_irq == (flag_r && cmp_ctrl_r[3]
        && global_irq_enable))
        else $error("interrupt gating wrong");
    vector_clear_a: assert property (vector_taken && !event_hit |=> !flag_r)
        else $error("flag not cleared by vector");
    reserved_zero_a: assert property (rd_en && word_idx == `IDX_CMP_CTRL
        |=> prdata[2] == 1'b0)
        else $error("reserved bit read nonzero");
    buffer_read_a: assert property (rd_en && word_idx == `IDX_PIN_READ
        && dig_in_dis_r[0] |=> prdata[0] == 1'b0)
        else $error("disabled pin read nonzero");
    ccb_ro_a: assert property (conv_ctrl_b_r[4:3] == 2'b00)
        else $error("read-only bits changed");

    // ------------------------------------------------------------------
    // Event and flag assertions
    // ------------------------------------------------------------------
    // Edges are judged on the synchronized value only, never on the raw pin
    sync_stage_a: assert property (sync1_r == $past(comparator_raw))
        else $error("first sync stage not one cycle behind raw");
    edge_history_a: assert property (prev_r == $past(sync2_r))
        else $error("previous sample not one cycle old");
    toggle_sets_a: assert property (cmp_ctrl_r[1:0] == 2'b00 && $changed(sync2_r)
        |=> flag_r)
        else $error("toggle missed");
    fall_sets_a: assert property (cmp_ctrl_r[1:0] == 2'b10 && $fell(sync2_r)
        |=> flag_r)
        else $error("falling edge missed");
    fall_ignored_a: assert property (cmp_ctrl_r[1:0] == 2'b11 && !flag_r
        && !$rose(sync2_r) |=> !flag_r)
        else $error("rising mode set flag without rise");
    rise_ignored_a: assert property (cmp_ctrl_r[1:0] == 2'b10 && !flag_r
        && !$fell(sync2_r) |=> !flag_r)
        else $error("falling mode set flag without fall");
    flag_source_a: assert property (!flag_r && !event_hit
        |=> !flag_r)
        else $error("flag set without event");
    set_wins_a: assert property (event_hit
        |=> flag_r)
        else $error("event lost against a clear");
    sticky_flag_a: assert property (flag_r && !vector_taken && !wr_en
        |=> flag_r)
        else $error("flag dropped on its own");
    w1c_status_a: assert property (wr_en && pstrb[0] && pwdata[0]
        && word_idx == `IDX_IRQ_STATUS && !event_hit |=> !flag_r)
        else $error("status write one did not clear");
    w1c_ctrl_a: assert property (wr_en && pstrb[0] && pwdata[`CMP_FLAG_BIT]
        && word_idx == `IDX_CMP_CTRL && !event_hit |=> !flag_r)
        else $error("control write one did not clear");
    w0_keeps_a: assert property (flag_r && wr_en && !pwdata[`CMP_FLAG_BIT]
        && word_idx == `IDX_CMP_CTRL && !vector_taken |=> flag_r)
        else $error("write zero cleared flag");
    result_read_a: assert property (rd_en && word_idx == `IDX_CMP_CTRL
        |=> prdata[5] == $past(sync2_r))
        else $error("result bit read wrong");
    flag_read_a: assert property (rd_en && word_idx == `IDX_IRQ_STATUS
        |=> prdata[0] == $past(flag_r))
        else $error("status flag read wrong");

    // ------------------------------------------------------------------
    // Control output assertions
    // ------------------------------------------------------------------
    ctrl_out_a: assert property (wr_en && pstrb[0] && word_idx == `IDX_CMP_CTRL
        |=> {24'h00_0000, comparator_power_off, bandgap_select, 6'h00}
            == ($past(pwdata) & 32'h0000_00c0))
        else $error("power or bandgap output wrong");
    power_read_a: assert property (rd_en && word_idx == `IDX_CMP_CTRL
        |=> prdata[7] == $past(comparator_power_off))
        else $error("power off bit read wrong");
    ccb_write_a: assert property (wr_en && pstrb[0] && word_idx == `IDX_CONV_CTRL_B
        |=> {24'h00_0000, conv_ctrl_b_r} == ($past(pwdata) & {24'h00_0000, `CCB_WR_MASK}))
        else $error("converter control b write wrong");
    buffer_out_a: assert property (wr_en && pstrb[0] && word_idx == `IDX_DIG_IN_DIS
        |=> {30'h0000_0000, negative_pin_buffer_off, positive_pin_buffer_off}
            == ($past(pwdata) & 32'h0000_0003))
        else $error("buffer disable outputs wrong");
    converter_blocks_a: assert property (conv_ctrl_a_r[7]
        |-> negative_source == NEG_PIN)
        else $error("converter on but mux routed");
    irq_off_a: assert property (!global_irq_enable
        |-> !comparator_irq)
        else $error("interrupt without global enable");
    enable_off_a: assert property (!cmp_ctrl_r[`CMP_IRQ_EN_BIT]
        |-> !comparator_irq)
        else $error("interrupt without its enable");

    flag_set_c:   cover property (!flag_r ##1 flag_r);
    irq_fire_c:   cover property (comparator_irq);
    mux_input_c:  cover property (negative_source == NEG_INPUT3);
    fall_mode_c:  cover property (cmp_ctrl_r[1:0] == 2'b10 ##1 flag_r);
    toggle_mode_c: cover property (cmp_ctrl_r[1:0] == 2'b00 ##1 flag_r);

endmodule : comparator_control_logic

// ---- design/comparator_control_pkg.sv ----
// Types shared by the comparator control block
package comparator_control_pkg;

    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALLING  = 2'b10,
        MODE_RISING   = 2'b11
    } event_mode_t;

    typedef enum logic [2:0] {
        NEG_PIN    = 3'b000,
        NEG_INPUT0 = 3'b100,
        NEG_INPUT1 = 3'b101,
        NEG_INPUT2 = 3'b110,
        NEG_INPUT3 = 3'b111
    } neg_source_t;

endpackage : comparator_control_pkg

// ---- tb/comparator_control_logic_tb.sv ----
// Self-checking testbench for the comparator control logic
`timescale 1ns/1ps
module comparator_control_logic_tb;
    import comparator_control_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, raw, pos_dig = 1, neg_dig = 1, gie = 0, vtak = 0;
    logic        pwr_off, bg_sel, pbuf_off, nbuf_off, cirq, irq, err;
    logic [15:0] pos_mv = 16'h01f4;
    logic [7:0]  rd;
    neg_source_t nsrc;
    int          n_mismatch = 0, compares = 0;

    always #2.5 pclk = ~pclk;

    comparator_control_logic dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_raw(raw),
        .positive_pin_digital(pos_dig), .negative_pin_digital(neg_dig),
        .global_irq_enable(gie), .vector_taken(vtak), .comparator_power_off(pwr_off),
        .bandgap_select(bg_sel), .negative_source(nsrc),
        .positive_pin_buffer_off(pbuf_off), .negative_pin_buffer_off(nbuf_off),
        .comparator_irq(cirq), .irq(irq));
    comparator_core_model core (.power_off(pwr_off), .bandgap_select(bg_sel),
        .negative_source(nsrc), .pos_mv(pos_mv), .raw(raw));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) n_mismatch++;
        err = pslverr;
        rd  = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
        // Outputs launched by the access edge are judged one edge later
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask : rchk

    task automatic set_pos(input logic [15:0] mv);
        @(posedge pclk);
        pos_mv <= mv;
        repeat (5) @(posedge pclk);
    endtask : set_pos

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rchk(8'h0c, 8'h00);
        rchk(8'h20, 8'h00);
        rchk(8'h50, 8'h00);
        wr(8'h0c, 8'hbf);
        rchk(8'h0c, 8'ha7);
        wr(8'h0c, 8'h00);
        wr(8'h20, 8'hc4);
        chk({6'h0, pwr_off, bg_sel}, 8'h03);
        rchk(8'h20, 8'hc0);
        wr(8'h20, 8'h41);
        repeat (4) @(posedge pclk);
        rchk(8'h20, 8'h61);
        wr(8'h20, 8'h01);
        wr(8'h50, 8'hff);
        rchk(8'h50, 8'h3f);
        chk({6'h0, nbuf_off, pbuf_off}, 8'h03);
        rchk(8'h90, 8'h00);
        wr(8'h50, 8'h02);
        rchk(8'h90, 8'h01);
        wr(8'h50, 8'h00);
        rchk(8'h90, 8'h03);
        apb(1'b0, 8'hfc, 8'h00);
        chk({7'h0, err}, 8'h01);
    endtask : t_regs

    task automatic t_mux;
        logic [2:0] exp;
        for (int i = 0; i < 16; i++) begin
            wr(8'h0c, {1'b0, i[3], 6'h0});
            wr(8'h80, {i[2], 7'h0});
            wr(8'h84, {6'h0, i[1:0]});
            exp = (i[3] && !i[2]) ? {1'b1, i[1:0]} : 3'b000;
            chk({5'h0, nsrc}, {5'h0, exp});
            repeat (2) @(posedge pclk);
            rchk(8'h20, {2'b00, exp[2] & ~exp[0], 5'h01});
        end
        wr(8'h0c, 8'h00);
        wr(8'h80, 8'h00);
    endtask : t_mux

    task automatic t_events;
        for (int m = 0; m < 4; m++) begin
            wr(8'h20, {6'h04, m[1:0]});
            set_pos(16'h05dc);
            rchk(8'h20, {3'b001, m == 0 || m == 3, 2'b00, m[1:0]});
            wr(8'h20, {6'h04, m[1:0]});
            rchk(8'h20, {6'h08, m[1:0]});
            set_pos(16'h01f4);
            rchk(8'h20, {3'b000, m == 0 || m == 2, 2'b00, m[1:0]});
        end
    endtask : t_events

    task automatic t_irq;
        wr(8'h20, 8'h13);
        set_pos(16'h05dc);
        wr(8'h20, 8'h0b);
        chk({7'h0, cirq}, 8'h00);
        @(posedge pclk);
        gie <= 1'b1;
        @(posedge pclk);
        #1 chk({7'h0, cirq}, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(8'h8c, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rchk(8'h88, 8'h01);
        wr(8'h88, 8'h01);
        chk({6'h0, cirq, irq}, 8'h00);
        set_pos(16'h01f4);
        set_pos(16'h05dc);
        chk({7'h0, cirq}, 8'h01);
        @(posedge pclk);
        vtak <= 1'b1;
        @(posedge pclk);
        vtak <= 1'b0;
        rchk(8'h20, 8'h2b);
        wr(8'h20, 8'h03);
        gie <= 1'b0;
    endtask : t_irq

    task automatic print_verdict;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mux();
        t_events();
        t_irq();
        print_verdict();
    end

    // A hang past several times the expected run length ends the test
    initial begin
        #50000;
        n_mismatch++;
        print_verdict();
    end
endmodule : comparator_control_logic_tb

// ---- tb/comparator_core_model.sv ----
// Behavioural model of the analog comparator core and its input pins
`timescale 1ns/1ps
module comparator_core_model #(
    parameter logic [15:0] BANDGAP_MV = 16'h044c,
    parameter logic [15:0] NEG_PIN_MV = 16'h03e8
) (
    input  wire logic                           power_off,
    input  wire logic                           bandgap_select,
    input  wire comparator_control_pkg::neg_source_t negative_source,
    input  wire logic [15:0]                    pos_mv,
    output logic                                raw
);
    import comparator_control_pkg::*;
    // Converter inputs 0..3 sit at distinct levels so a wrong pick shows up
    localparam logic [15:0] CONV_MV [4] = '{16'h0064, 16'h0384, 16'h012c, 16'h02bc};
    logic [15:0] plus_mv;
    logic [15:0] minus_mv;
    always_comb begin
        plus_mv  = bandgap_select ? BANDGAP_MV : pos_mv;
        minus_mv = negative_source[2] ? CONV_MV[negative_source[1:0]] : NEG_PIN_MV;
        // A powered-down core makes no decision and rests low
        raw = !power_off && (plus_mv > minus_mv);
    end
endmodule : comparator_core_model
